// File: eed_check_sva.sv
// port assertions for the ecc error log block
// bound to eed_ecc_error_status; clk_en assumed held high
`timescale 1ns/10ps
module eed_check_sva (
  // clock and reset
  input wire mclk,
  input wire sys_rst,
  // host side
  input wire mem_protect_n,
  input wire sys_req,
  input wire sys_ack,
  input wire lcl_ack,
  input wire io_req,
  input wire io_ack,
  input wire [7:0] io_rdata,
  // array side and interrupt
  input wire ram_re,
  input wire ram_we,
  input wire ram_check_we,
  input wire err_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_rd3;
    ram_re[*3];
  endsequence
  sequence s_wr3;
    ram_we[*3] ##1 !ram_we;
  endsequence
  a_read_len: assert property ($rose(ram_re) |-> s_rd3)
    else $error("read strobe too short");
  a_ext_bound: assert property ($fell(ram_re) |->
    ##[0:2] (sys_ack || lcl_ack || ram_we))
    else $error("read not answered in time");
  a_wr_len: assert property ($rose(ram_we) |-> s_wr3)
    else $error("write strobe length wrong");
  a_protect_hold: assert property ((!mem_protect_n)[*8] |->
    !ram_re && !ram_we)
    else $error("array touched while protected");
  a_bit7_one: assert property (io_ack |-> io_rdata[7])
    else $error("log top bit low");
  a_io_answer: assert property (io_req && !io_ack |=> io_ack)
    else $error("io port not answered");
  a_ack_release: assert property (sys_ack && !sys_req |=> !sys_ack)
    else $error("ack held after request dropped");
  a_one_port: assert property (!(sys_ack && lcl_ack))
    else $error("both ports acked");
  a_check_gate: assert property (ram_check_we |-> ram_we)
    else $error("check write without data write");
  a_irq_pulse: assert property (err_irq |=> !err_irq)
    else $error("interrupt longer than a pulse");
endmodule

// File: eed_defines.vh
// constants for the ecc error log and access gating block
// included by eed_ecc_error_status.v only
`ifndef EED_DEFINES_VH
`define EED_DEFINES_VH

// clock and access timing, in ns
`define EED_CLK_NS 100
`define EED_SYS_ACC_NS 380
`define EED_LCL_ACC_NS 340
`define EED_EXT_NS 255

// error log layout and codes
`define EED_LOG_RESET 8'h9E
`define EED_LOG_ONE_BIT 7
`define EED_LOG_ROW_HI 6
`define EED_LOG_ROW_LO 5
`define EED_CODE_CHECK 5'h10
`define EED_CODE_NONE 5'h1E
`define EED_CODE_MULTI 5'h1F

// mode control fields
`define EED_MODE_INT_ANY 0
`define EED_MODE_CORRECT 1
`define EED_MODE_DIAG 2
`define EED_MODE_EXAMINE 3
`define EED_MODE_RESET 4'h3

// board size and address decode
`define EED_WORD_BITS 18
`define EED_ROW_HI 17
`define EED_ROW_LO 16
`define EED_SYS_BLKS 8'h20
`define EED_LCL_BLKS 8'h08
`define EED_LCL_FIRST_MB 8'h10
`define EED_LCL_MAX_BASE 8'h80

`endif

// File: eed_ecc_error_status.v
// ecc error log, mode control and dual port access gating for a dram board
// assumes external dram array with 16 data and 6 check bits, inputs
// synchronous to mclk, 4-phase req/ack on both memory ports
`timescale 1ns/10ps
`include "eed_defines.vh"

module eed_ecc_error_status (
  // clock, reset, enable
  input wire mclk,
  input wire sys_rst,
  input wire clk_en,
  // protect and jumpers
  input wire mem_protect_n,
  input wire [1:0] sys_page_sel,
  input wire [7:0] sys_base_blk,
  input wire [7:0] lcl_base_blk,
  // system bus port
  input wire sys_req,
  input wire sys_wr,
  input wire sys_byte,
  input wire [23:0] sys_addr,
  input wire [15:0] sys_wdata,
  output wire [15:0] sys_rdata,
  output wire sys_ack,
  // local extension bus port
  input wire lcl_req,
  input wire lcl_wr,
  input wire lcl_byte,
  input wire [23:0] lcl_addr,
  input wire [15:0] lcl_wdata,
  output wire [15:0] lcl_rdata,
  output wire lcl_ack,
  // io port
  input wire io_req,
  input wire io_wr,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  output wire io_ack,
  // dram array
  output reg [17:0] ram_addr,
  output wire ram_re,
  output wire ram_we,
  output wire ram_check_we,
  output reg [15:0] ram_wdata,
  output reg [5:0] ram_wcheck,
  input wire [15:0] ram_rdata,
  input wire [5:0] ram_rcheck,
  // interrupt
  output reg err_irq
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD = 3'h1;
  localparam [2:0] ST_EXT = 3'h2;
  localparam [2:0] ST_WR = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;

  localparam integer SYS_CYC = `EED_SYS_ACC_NS / `EED_CLK_NS;
  localparam integer LCL_CYC = `EED_LCL_ACC_NS / `EED_CLK_NS;
  localparam integer EXT_CYC = `EED_EXT_NS / `EED_CLK_NS;

  // column code of each data bit in the check matrix
  function [5:0] eed_col;
    input [3:0] n;
    begin
      case (n)
        4'h0: eed_col = 6'h07;
        4'h1: eed_col = 6'h0B;
        4'h2: eed_col = 6'h0D;
        4'h3: eed_col = 6'h0E;
        4'h4: eed_col = 6'h13;
        4'h5: eed_col = 6'h15;
        4'h6: eed_col = 6'h16;
        4'h7: eed_col = 6'h19;
        4'h8: eed_col = 6'h1A;
        4'h9: eed_col = 6'h1C;
        4'hA: eed_col = 6'h23;
        4'hB: eed_col = 6'h25;
        4'hC: eed_col = 6'h26;
        4'hD: eed_col = 6'h29;
        4'hE: eed_col = 6'h2A;
        default: eed_col = 6'h2C;
      endcase
    end
  endfunction

  function [5:0] eed_check;
    input [15:0] d;
    integer i;
    begin
      eed_check = 6'h00;
      for (i = 0; i < 16; i = i + 1) begin
        if (d[i])
          eed_check = eed_check ^ eed_col(i[3:0]);
      end
    end
  endfunction

  // syndrome to failing-bit code
  function [4:0] eed_locate;
    input [5:0] syn;
    integer i;
    begin
      eed_locate = `EED_CODE_MULTI;
      for (i = 0; i < 16; i = i + 1) begin
        if (syn == eed_col(i[3:0]))
          eed_locate = i[4:0];
      end
      for (i = 0; i < 6; i = i + 1) begin
        if (syn == (6'h01 << i))
          eed_locate = `EED_CODE_CHECK + i[4:0];
      end
      if (syn == 6'h00)
        eed_locate = `EED_CODE_NONE;
    end
  endfunction

  reg [2:0] state_reg;
  reg [2:0] cnt_reg;
  reg port_reg;
  reg wr_reg;
  reg rmw_reg;
  reg hi_reg;
  reg [15:0] bus_wdata_reg;
  reg [15:0] rdata_reg;
  reg [7:0] log_reg;
  reg [3:0] mode_reg;
  reg io_done_reg;

  // address decode, system bus
  wire [7:0] sys_diff = sys_addr[21:14] - sys_base_blk;
  wire sys_hit = (sys_addr[23:22] == sys_page_sel) &&
    (sys_addr[21:14] >= sys_base_blk) &&
    (sys_diff < `EED_SYS_BLKS);
  wire [18:0] sys_off = {sys_diff[4:0], sys_addr[13:0]};

  // address decode, local bus
  wire [7:0] lcl_diff = lcl_addr[23:16] - lcl_base_blk;
  wire lcl_base_ok = (lcl_base_blk < `EED_LCL_FIRST_MB) ||
    ((lcl_base_blk[2:0] == 3'h0) &&
    (lcl_base_blk < `EED_LCL_MAX_BASE));
  wire lcl_hit = lcl_base_ok && (lcl_addr[23:16] >= lcl_base_blk) &&
    (lcl_diff < `EED_LCL_BLKS);
  wire [18:0] lcl_off = {lcl_diff[2:0], lcl_addr[15:0]};

  wire take_lcl = lcl_req && lcl_hit;
  wire take_sys = sys_req && sys_hit;

  // read side checking
  wire [5:0] syn = ram_rcheck ^ eed_check(ram_rdata);
  wire [4:0] code = eed_locate(syn);
  wire [15:0] fix_mask = (mode_reg[`EED_MODE_CORRECT] && !code[4]) ?
    (16'h0001 << code[3:0]) : 16'h0000;
  wire [15:0] rd_fixed = ram_rdata ^ fix_mask;
  wire [15:0] merged = hi_reg ? {bus_wdata_reg[15:8], rd_fixed[7:0]} :
    {rd_fixed[15:8], bus_wdata_reg[7:0]};
  wire [1:0] row = ram_addr[`EED_ROW_HI:`EED_ROW_LO];
  wire [2:0] port_cyc = port_reg ? SYS_CYC[2:0] : LCL_CYC[2:0];
  wire rd_last = (state_reg == ST_RD) && (cnt_reg == port_cyc - 3'h1);

  assign ram_re = (state_reg == ST_RD);
  assign ram_we = (state_reg == ST_WR);
  assign ram_check_we = ram_we &&
    !mode_reg[`EED_MODE_DIAG];
  assign sys_ack = (state_reg == ST_HOLD) && port_reg;
  assign lcl_ack = (state_reg == ST_HOLD) && !port_reg;
  assign sys_rdata = rdata_reg;
  assign lcl_rdata = rdata_reg;
  assign io_ack = io_done_reg;

  // memory access sequencer
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      port_reg <= 1'b0;
      wr_reg <= 1'b0;
      rmw_reg <= 1'b0;
      hi_reg <= 1'b0;
      bus_wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      ram_addr <= 18'h00000;
      ram_wdata <= 16'h0000;
      ram_wcheck <= 6'h00;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 3'h0;
          // protect blocks new access entirely
          if (mem_protect_n && (take_lcl || take_sys)) begin
            port_reg <= !take_lcl;
            if (take_lcl) begin
              wr_reg <= lcl_wr;
              rmw_reg <= lcl_wr && lcl_byte;
              hi_reg <= lcl_addr[0];
              bus_wdata_reg <= lcl_wdata;
              ram_addr <= lcl_off[18:1];
              ram_wdata <= lcl_wdata;
              ram_wcheck <= eed_check(lcl_wdata);
              state_reg <= (lcl_wr && !lcl_byte) ? ST_WR : ST_RD;
            end else begin
              wr_reg <= sys_wr;
              rmw_reg <= sys_wr && sys_byte;
              hi_reg <= sys_addr[0];
              bus_wdata_reg <= sys_wdata;
              ram_addr <= sys_off[18:1];
              ram_wdata <= sys_wdata;
              ram_wcheck <= eed_check(sys_wdata);
              state_reg <= (sys_wr && !sys_byte) ? ST_WR : ST_RD;
            end
          end
        end
        ST_RD: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (rd_last) begin
            cnt_reg <= 3'h0;
            rdata_reg <= rd_fixed;
            if (rmw_reg) begin
              // byte write: merge and rewrite whole word
              ram_wdata <= merged;
              ram_wcheck <= eed_check(merged);
              state_reg <= ST_WR;
            end else if (syn != 6'h00) begin
              state_reg <= ST_EXT;
            end else begin
              state_reg <= ST_HOLD;
            end
          end
        end
        ST_EXT: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == EXT_CYC[2:0] - 3'h1) begin
            cnt_reg <= 3'h0;
            state_reg <= ST_HOLD;
          end
        end
        ST_WR: begin
          cnt_reg <= cnt_reg + 3'h1;
          if (cnt_reg == port_cyc - 3'h1) begin
            cnt_reg <= 3'h0;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // 4-phase: ack holds until the request drops
          if (port_reg ? !sys_req : !lcl_req)
            state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // error log, mode control and interrupt
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      log_reg <= `EED_LOG_RESET;
      mode_reg <= `EED_MODE_RESET;
      err_irq <= 1'b0;
      io_rdata <= 8'h00;
      io_done_reg <= 1'b0;
    end else if (clk_en) begin
      err_irq <= 1'b0;
      io_done_reg <= io_req;
      if (io_req && !io_done_reg) begin
        if (io_wr)
          mode_reg <= io_wdata[3:0];
        else
          io_rdata <= log_reg;
      end
      if (mode_reg[`EED_MODE_EXAMINE]) begin
        // transparent logging of raw bits
        if (rd_last)
          log_reg <= {1'b1, 1'b0, syn};
        else if ((state_reg == ST_WR) && (cnt_reg == 3'h0))
          log_reg <= {1'b1, 1'b0, ram_wcheck};
      end else if (rd_last && (syn != 6'h00)) begin
        // latest error overwrites
        log_reg <= {1'b1, row, code};
      end
      if (rd_last && (syn != 6'h00))
        err_irq <= mode_reg[`EED_MODE_INT_ANY] ||
          (code == `EED_CODE_MULTI);
    end
  end

endmodule

// File: eed_ecc_error_status_bench.sv
// self-checking bench for eed_ecc_error_status
// system page 1 base block 4, local base block 8
`timescale 1ns/10ps
module eed_ecc_error_status_bench;
  logic mclk, sys_rst, mem_protect_n, sys_req, lcl_req, acc_wr, acc_byte;
  logic io_req, io_wr;
  logic [23:0] acc_addr;
  logic [15:0] acc_wdata, q;
  logic [7:0] io_wdata, lq;
  logic [21:0] flip_mask;
  wire [15:0] sys_rdata, lcl_rdata, ram_wdata, ram_rdata;
  wire [17:0] ram_addr;
  wire [5:0] ram_wcheck, ram_rcheck;
  wire [7:0] io_rdata;
  wire sys_ack, lcl_ack, io_ack, ram_re, ram_we, ram_check_we, err_irq;
  int compares = 0, miscompares = 0, cyc = 0, n, nw, nb, irqs = 0;
  logic [21:0] flips [5] = '{22'h000001, 22'h008000, 22'h010000,
    22'h200000, 22'h000003};
  logic [4:0] codes [5] = '{5'h00, 5'h0F, 5'h10, 5'h15, 5'h1F};
  eed_ecc_error_status dut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
    .mem_protect_n(mem_protect_n), .sys_page_sel(2'h1),
    .sys_base_blk(8'h04), .lcl_base_blk(8'h08), .sys_req(sys_req),
    .sys_wr(acc_wr), .sys_byte(acc_byte), .sys_addr(acc_addr),
    .sys_wdata(acc_wdata), .sys_rdata(sys_rdata), .sys_ack(sys_ack),
    .lcl_req(lcl_req), .lcl_wr(acc_wr), .lcl_byte(acc_byte),
    .lcl_addr(acc_addr), .lcl_wdata(acc_wdata), .lcl_rdata(lcl_rdata),
    .lcl_ack(lcl_ack), .io_req(io_req), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack),
    .ram_addr(ram_addr), .ram_re(ram_re), .ram_we(ram_we),
    .ram_check_we(ram_check_we), .ram_wdata(ram_wdata),
    .ram_wcheck(ram_wcheck), .ram_rdata(ram_rdata),
    .ram_rcheck(ram_rcheck), .err_irq(err_irq));
  eed_ram_model ram (.mclk(mclk), .ram_re(ram_re), .ram_we(ram_we),
    .ram_check_we(ram_check_we), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_wcheck(ram_wcheck),
    .flip_mask(flip_mask), .ram_rdata(ram_rdata), .ram_rcheck(ram_rcheck));
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // n reaches 30 when the access is never acked
  task automatic mem(input logic lcl, wr, by, input logic [23:0] a,
    input logic [15:0] d);
    acc_wr = wr; acc_byte = by; acc_addr = a; acc_wdata = d;
    sys_req = !lcl; lcl_req = lcl; n = 0;
    while (!(lcl ? lcl_ack : sys_ack) && n < 30) begin
      @(posedge mclk); #1; n++;
    end
    q = lcl ? lcl_rdata : sys_rdata;
    sys_req = 0; lcl_req = 0;
    repeat (2) begin @(posedge mclk); #1; end
  endtask
  task automatic io(input logic wr, input logic [7:0] d);
    io_req = 1; io_wr = wr; io_wdata = d; n = 0;
    while (!io_ack && n < 4) begin @(posedge mclk); #1; n++; end
    lq = io_rdata;
    io_req = 0; io_wr = 0;
    repeat (2) begin @(posedge mclk); #1; end
  endtask
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin mclk = 0; forever #50 mclk = ~mclk; end
  always @(posedge mclk) begin
    cyc++;
    // one registered pulse per interrupting error
    if (err_irq === 1'b1) irqs++;
    if (cyc == 3000) begin miscompares++; finish_test; end
  end
  initial begin
    sys_rst = 1; mem_protect_n = 1; sys_req = 0; lcl_req = 0; acc_wr = 0;
    acc_byte = 0; acc_addr = 0; acc_wdata = 0; io_req = 0; io_wr = 0;
    io_wdata = 0; flip_mask = 0;
    repeat (6) @(posedge mclk);
    #1 sys_rst = 0;
    io(0, 8'h00); chk("reset log", 16'h009E, {8'h00, lq});
    mem(0, 1, 0, 24'h450000, 16'hA5C3); nw = n;
    mem(1, 0, 0, 24'h0C0000, 16'h0); chk("local read", 16'hA5C3, q);
    for (int i = 0; i < 5; i++) begin
      flip_mask = flips[i];
      mem(0, 0, 0, 24'h450000, 16'h0);
      flip_mask = 0;
      if (i < 4) chk("fixed data", 16'hA5C3, q);
      io(0, 8'h00); chk("log", {9'h001, 2'h2, codes[i]}, {8'h00, lq});
    end
    chk("irq any", 16'h0005, irqs[15:0]);
    io(1, 8'h0A);
    flip_mask = 22'h000001;
    mem(0, 0, 0, 24'h450000, 16'h0);
    flip_mask = 0;
    io(0, 8'h00); chk("syndrome log", 16'h0087, {8'h00, lq});
    io(1, 8'h03);
    mem(1, 1, 1, 24'h0C0001, 16'h7E00); nb = n;
    mem(0, 0, 0, 24'h450000, 16'h0); chk("merged", 16'h7EC3, q);
    chk("byte longer", 16'h0001, {15'h0, nb > nw});
    // diagnostic keeps old check bits, so a one-bit change reads as error
    io(1, 8'h0C); mem(0, 1, 0, 24'h450000, 16'h7EC2);
    mem(0, 0, 0, 24'h450000, 16'h0); chk("raw data", 16'h7EC2, q);
    io(0, 8'h00); chk("diag syndrome", 16'h0087, {8'h00, lq});
    chk("irq single", 16'h0005, irqs[15:0]);
    flip_mask = 22'h000002;
    mem(0, 0, 0, 24'h450000, 16'h0);
    flip_mask = 0;
    chk("irq multi", 16'h0006, irqs[15:0]);
    io(1, 8'h03);
    mem(0, 0, 0, 24'h450000, 16'h0); chk("corrected", 16'h7EC3, q);
    mem_protect_n = 0;
    mem(0, 0, 0, 24'h450000, 16'h0); chk("protect", 16'h001E, n[15:0]);
    mem_protect_n = 1;
    mem(0, 0, 0, 24'h050000, 16'h0);
    chk("page miss", 16'h001E, n[15:0]);
    mem(0, 0, 0, 24'h490000, 16'h0);
    chk("base miss", 16'h001E, n[15:0]);
    finish_test;
  end
endmodule
bind eed_ecc_error_status eed_check_sva u_sva (.mclk(mclk),
  .sys_rst(sys_rst), .mem_protect_n(mem_protect_n), .sys_req(sys_req),
  .sys_ack(sys_ack), .lcl_ack(lcl_ack), .io_req(io_req), .io_ack(io_ack),
  .io_rdata(io_rdata), .ram_re(ram_re), .ram_we(ram_we),
  .ram_check_we(ram_check_we), .err_irq(err_irq));

// File: eed_ram_model.sv
// dram array model with 16 data and 6 check bits
// flip_mask from the bench corrupts read data to make errors
`timescale 1ns/10ps
module eed_ram_model (
  // clock and strobes
  input wire mclk,
  input wire ram_re,
  input wire ram_we,
  input wire ram_check_we,
  // address and data
  input wire [17:0] ram_addr,
  input wire [15:0] ram_wdata,
  input wire [5:0] ram_wcheck,
  input wire [21:0] flip_mask,
  output wire [15:0] ram_rdata,
  output wire [5:0] ram_rcheck
);
  logic [21:0] mem [0:262143];
  logic [21:0] last_q = 22'h0;
  // released bus shows inverse of last word
  assign {ram_rcheck, ram_rdata} = ram_re ? mem[ram_addr] ^ flip_mask
    : ~last_q;
  always @(posedge mclk) begin
    if (ram_re) last_q <= mem[ram_addr] ^ flip_mask;
    if (ram_we) mem[ram_addr][15:0] <= ram_wdata;
    if (ram_check_we) mem[ram_addr][21:16] <= ram_wcheck;
  end
endmodule
